// file: hdl/tstamp_pkg.sv
// Package for the time stamp and packet counter unit.
// Assumes a single 250 MHz core clock; no software-visible registers.
package tstamp_pkg;

   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int CLK_MHZ = 250;              // Core clock rate
   localparam int FINE_TICK_US_X10 = 1;       // Fine tick, 0.1 ms as tenths of a ms
   localparam int FINE_TICK_CYC = CLK_MHZ * 100 * FINE_TICK_US_X10;   // 25000 cycles
   localparam int NS_PER_CYC = 1000 / CLK_MHZ;                        // 4 ns per cycle
   localparam logic [31:0] NS_PER_SEC = 32'd1000000000;
   localparam logic [31:0] NS_STEP = 32'h0000_0004;

   // ----------------------------------------
   // Calendar record layout and limits
   // ----------------------------------------
   localparam int OFS_NS = 0;
   localparam int OFS_YEAR = 4;
   localparam int OFS_MONTH = 6;
   localparam int OFS_DAY = 7;
   localparam int OFS_HOUR = 8;
   localparam int OFS_MIN = 9;
   localparam int OFS_SEC = 10;
   localparam int OFS_FLAGS = 11;
   localparam int REC_BYTES = 12;
   localparam logic [15:0] YEAR_MIN = 16'd1999;
   localparam logic [15:0] YEAR_MAX = 16'd2099;
   localparam logic [7:0] FLAG_TOW_OK = 8'h01;
   localparam logic [7:0] FLAG_WEEK_OK = 8'h02;
   localparam logic [7:0] FLAG_UTC_OK = 8'h04;

   // Reset value: zero seconds into the first supported day
   localparam logic [15:0] RST_YEAR = 16'd1999;
   localparam logic [7:0] RST_MONTH = 8'h01;
   localparam logic [7:0] RST_DAY = 8'h01;

   // ----------------------------------------
   // Carried types
   // ----------------------------------------
   typedef struct packed {
      logic [31:0] nsec;
      logic [15:0] year;
      logic [7:0] month;
      logic [7:0] day;
      logic [7:0] hour;
      logic [7:0] minute;
      logic [7:0] second;
      logic [7:0] flags;
   } cal_time_t;

   typedef struct packed {
      logic add_count;   // Message carries the packet counter
      logic add_cal;     // Message carries the calendar time record
      logic add_fine;    // Message carries the fine time stamp
   } tag_cfg_t;

   typedef struct packed {
      logic [15:0] count;
      cal_time_t cal;
      logic [31:0] fine;
      tag_cfg_t has;
   } msg_tag_t;

   typedef enum logic [2:0] {
      SRC_ZERO = 3'b001,
      SRC_NVM = 3'b010,
      SRC_SAT = 3'b100
   } time_src_t;

endpackage : tstamp_pkg

// file: hdl/cal_date_step.sv
// Combinational calendar step: next day with month lengths and leap years.
// Assumes a year in the supported range; the last year does not roll on.
`timescale 1ns/1ps
module cal_date_step (
   input wire logic [15:0] year,          // Current year
   input wire logic [7:0] month,          // Current month 1..12
   input wire logic [7:0] day,            // Current day 1..31
   output logic [15:0] year_nxt,          // Year after one day
   output logic [7:0] month_nxt,          // Month after one day
   output logic [7:0] day_nxt             // Day after one day
);
   logic leap;
   logic [7:0] last_day;

   // ----------------------------------------
   // Month length (range 1999..2099 has no century exception but 2100)
   // ----------------------------------------
   assign leap = (year[1:0] == 2'h0);
   always_comb begin
      case (month)
         8'h02: last_day = leap ? 8'h1d : 8'h1c;
         8'h04, 8'h06, 8'h09, 8'h0b: last_day = 8'h1e;
         default: last_day = 8'h1f;
      endcase
   end

   // Carry day into month into year, clamp at the last year
   always_comb begin
      year_nxt = year;
      month_nxt = month;
      day_nxt = day + 8'h01;
      if (day >= last_day) begin
         day_nxt = 8'h01;
         month_nxt = month + 8'h01;
         if (month >= 8'h0c) begin
            month_nxt = 8'h01;
            year_nxt = year + 16'h0001;
            if (year >= tstamp_pkg::YEAR_MAX) begin
               year_nxt = tstamp_pkg::YEAR_MAX; // No roll past the last year
               month_nxt = 8'h0c;
               day_nxt = 8'h1f;
            end
         end
      end
   end
endmodule : cal_date_step

// file: hdl/timestamp_packet_counter.sv
// Time stamp and packet counter unit: counter, calendar time, fine stamp.
// Assumes message requests and time loads come from logic on core_clk.
//
// Summary of operation
// - Messages optionally carry counter, stamp, or both
// - Counter increments once per composed message
// - Counter value captured at compose time
// - Calendar layout used even if unsynchronised
// - Nanoseconds at offset 0, below one billion
// - Year at offset 4, 1999 to 2099
// - Month offset 6, day offset 7
// - Hour, minute, second at offsets 8-10
// - Flag byte 11: TOW, week, UTC valid
// - Start zero; stored time, satellite time override
// - Midnight wrap advances date one day; 2099-12-31 repeats
// - Fine stamp 32 bits, 0.1 ms steps
`timescale 1ns/1ps
module timestamp_packet_counter (
   input wire logic core_clk,                         // 250 MHz clock
   input wire logic rst_n,                            // Sync reset, active low
   input wire tstamp_pkg::tag_cfg_t cfg,              // Output configuration
   input wire logic compose,                          // Pulse: message composed
   input wire logic nvm_load,                         // Pulse: stored time valid
   input wire tstamp_pkg::cal_time_t nvm_time,        // Time from non-volatile memory
   input wire logic sat_load,                         // Pulse: satellite time valid
   input wire tstamp_pkg::cal_time_t sat_time,        // Time from satellite receiver
   output tstamp_pkg::msg_tag_t tag_r,                // Tag of composed message
   output logic tag_valid_r,                          // Pulse: tag_r updated
   output tstamp_pkg::cal_time_t cal_r,               // Running calendar time
   output logic [31:0] fine_r,                        // Running fine stamp
   output logic [2:0] src_r                           // Current time source
);
   logic [15:0] count_r;
   logic [14:0] tick_cnt_r;
   logic tick;
   logic sec_end;
   logic day_end;
   logic [15:0] year_nxt;
   logic [7:0] month_nxt;
   logic [7:0] day_nxt;
   logic [95:0] rec_bytes;

   // ----------------------------------------
   // Fine stamp
   // ----------------------------------------

   // Divider to one pulse per 0.1 ms
   always_ff @(posedge core_clk) begin
      if (!rst_n || tick) begin
         tick_cnt_r <= '0;
      end else begin
         tick_cnt_r <= tick_cnt_r + 15'h0001;
      end
   end
   assign tick = (tick_cnt_r == 15'(tstamp_pkg::FINE_TICK_CYC - 1));

   // Wraps freely at 32 bits
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         fine_r <= '0;
      end else if (tick) begin
         fine_r <= fine_r + 32'h0000_0001;
      end
   end

   // ----------------------------------------
   // Calendar time
   // ----------------------------------------
   assign sec_end = (cal_r.nsec >= tstamp_pkg::NS_PER_SEC - tstamp_pkg::NS_STEP);
   assign day_end = sec_end && cal_r.second == 8'h3b && cal_r.minute == 8'h3b && cal_r.hour == 8'h17;

   cal_date_step u_date (
      .year(cal_r.year),
      .month(cal_r.month),
      .day(cal_r.day),
      .year_nxt(year_nxt),
      .month_nxt(month_nxt),
      .day_nxt(day_nxt)
   );

   // Satellite beats stored beats zero; a lower source never overwrites
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         src_r <= tstamp_pkg::SRC_ZERO;
      end else if (sat_load) begin
         src_r <= tstamp_pkg::SRC_SAT;
      end else if (nvm_load && src_r != tstamp_pkg::SRC_SAT) begin
         src_r <= tstamp_pkg::SRC_NVM;
      end
   end

   // Runs in UTC layout whether or not synchronised
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cal_r.nsec <= '0;
         cal_r.year <= tstamp_pkg::RST_YEAR;
         cal_r.month <= tstamp_pkg::RST_MONTH;
         cal_r.day <= tstamp_pkg::RST_DAY;
         cal_r.hour <= '0;
         cal_r.minute <= '0;
         cal_r.second <= '0;
         cal_r.flags <= '0;
      end else if (sat_load) begin
         cal_r <= sat_time;
      end else if (nvm_load && src_r != tstamp_pkg::SRC_SAT) begin
         cal_r <= nvm_time;
      end else begin
         cal_r.nsec <= sec_end ? 32'h0 : cal_r.nsec + tstamp_pkg::NS_STEP;
         if (sec_end) begin
            cal_r.second <= (cal_r.second == 8'h3b) ? 8'h00 : cal_r.second + 8'h01;
            if (cal_r.second == 8'h3b) begin
               cal_r.minute <= (cal_r.minute == 8'h3b) ? 8'h00 : cal_r.minute + 8'h01;
               if (cal_r.minute == 8'h3b) begin
                  cal_r.hour <= (cal_r.hour == 8'h17) ? 8'h00 : cal_r.hour + 8'h01;
               end
            end
         end
         if (day_end) begin
            cal_r.year <= year_nxt;
            cal_r.month <= month_nxt;
            cal_r.day <= day_nxt;
         end
      end
   end

   // Byte image of the record, low offset in the top byte
   assign rec_bytes = {cal_r.nsec, cal_r.year, cal_r.month, cal_r.day, cal_r.hour, cal_r.minute,
                       cal_r.second, cal_r.flags};

   // ----------------------------------------
   // Packet counter and message tag
   // ----------------------------------------

   // One step per message, whatever it carries; wraps at 16 bits
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         count_r <= '0;
      end else if (compose) begin
         count_r <= count_r + 16'h0001;
      end
   end

   // Tag captured at composition, before any sending delay
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         tag_r <= '0;
         tag_valid_r <= 1'b0;
      end else begin
         tag_valid_r <= compose;
         if (compose) begin
            tag_r.count <= cfg.add_count ? count_r : 16'h0;
            tag_r.cal <= cfg.add_cal ? cal_r : '0;
            tag_r.fine <= cfg.add_fine ? fine_r : 32'h0;
            tag_r.has <= cfg;
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_compose_seen;
      compose ##1 tag_valid_r;
   endsequence

   a_count_step: assert property (@(posedge core_clk) disable iff (!rst_n)
      compose |=> count_r == $past(count_r) + 16'h0001)
      else $error("packet counter did not step on compose");
   a_count_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      !compose |=> count_r == $past(count_r))
      else $error("packet counter moved without compose");
   a_tag_capture: assert property (@(posedge core_clk) disable iff (!rst_n)
      (compose && cfg.add_count) |=> tag_r.count == $past(count_r) && tag_valid_r)
      else $error("tag lost counter value at compose");
   a_tag_omit: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_compose_seen |-> (tag_r.has.add_fine || tag_r.fine == 32'h0))
      else $error("fine stamp present though not selected");
   a_nsec_range: assert property (@(posedge core_clk) disable iff (!rst_n)
      src_r == tstamp_pkg::SRC_ZERO |-> rec_bytes[95:64] < tstamp_pkg::NS_PER_SEC)
      else $error("nanoseconds out of range");
   a_fine_tick: assert property (@(posedge core_clk) disable iff (!rst_n)
      tick |=> fine_r == $past(fine_r) + 32'h0000_0001 ##1 !tick [*8])
      else $error("fine stamp step wrong");
   a_midnight_date: assert property (@(posedge core_clk) disable iff (!rst_n)
      (day_end && !sat_load && !nvm_load) |=> cal_r.hour == 8'h00 && cal_r.day == $past(day_nxt))
      else $error("date not advanced at midnight");
   a_src_prio: assert property (@(posedge core_clk) disable iff (!rst_n)
      src_r == tstamp_pkg::SRC_SAT && !sat_load |=> src_r == tstamp_pkg::SRC_SAT)
      else $error("satellite time source overridden");
   a_year_cap: assert property (@(posedge core_clk) disable iff (!rst_n)
      src_r == tstamp_pkg::SRC_ZERO |-> cal_r.year <= tstamp_pkg::YEAR_MAX)
      else $error("year past last supported");

   // Field ranges while the unit keeps its own time; loaded values are trusted as given
   a_year_floor: assert property (@(posedge core_clk) disable iff (!rst_n)
      src_r == tstamp_pkg::SRC_ZERO |-> cal_r.year >= tstamp_pkg::YEAR_MIN)
      else $error("year below first supported");
   a_date_ranges: assert property (@(posedge core_clk) disable iff (!rst_n)
      src_r == tstamp_pkg::SRC_ZERO |-> cal_r.month >= 8'h01 && cal_r.month <= 8'h0c &&
         cal_r.day >= 8'h01 && cal_r.day <= 8'h1f)
      else $error("month or day out of range");
   a_time_ranges: assert property (@(posedge core_clk) disable iff (!rst_n)
      src_r == tstamp_pkg::SRC_ZERO |-> cal_r.hour <= 8'h17 && cal_r.minute <= 8'h3b &&
         cal_r.second <= 8'h3b)
      else $error("hour, minute or second out of range");
   // Seconds step at the end of each second when no load interferes
   a_sec_step: assert property (@(posedge core_clk) disable iff (!rst_n)
      (sec_end && !sat_load && !nvm_load && cal_r.second != 8'h3b) |=>
         cal_r.nsec == 32'h0 && cal_r.second == $past(cal_r.second) + 8'h01)
      else $error("second did not step");
   // Flags only change by a load; nothing inside sets them
   a_flags_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!sat_load && !nvm_load) |=> cal_r.flags == $past(cal_r.flags))
      else $error("flag byte changed without a load");
   // Source loads: satellite always taken, stored refused behind it
   a_sat_load: assert property (@(posedge core_clk) disable iff (!rst_n)
      sat_load |=> src_r == tstamp_pkg::SRC_SAT && cal_r == $past(sat_time))
      else $error("satellite time not taken");
   a_nvm_refused: assert property (@(posedge core_clk) disable iff (!rst_n)
      (nvm_load && !sat_load && src_r == tstamp_pkg::SRC_SAT && !sec_end) |=>
         cal_r.nsec == $past(cal_r.nsec) + tstamp_pkg::NS_STEP)
      else $error("stored time taken over satellite time");
   // Tag strobe only follows a compose
   a_valid_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
      !compose |=> !tag_valid_r)
      else $error("tag strobe without compose");
   // Last supported day repeats rather than rolling into an unsupported year
   a_last_day: assert property (@(posedge core_clk) disable iff (!rst_n)
      (day_end && !sat_load && !nvm_load && cal_r.year == tstamp_pkg::YEAR_MAX &&
         cal_r.month == 8'h0c && cal_r.day == 8'h1f) |=>
         cal_r.year == tstamp_pkg::YEAR_MAX && cal_r.month == 8'h0c && cal_r.day == 8'h1f)
      else $error("date rolled past last supported day");
endmodule : timestamp_packet_counter

// file: tb/tag_sink.sv
// Host-side model that receives tagged messages.
// Assumes tag_valid_r is a one-cycle pulse on core_clk.
`timescale 1ns/1ps
module tag_sink (
   input wire logic core_clk,               // Clock
   input wire logic rst_n,                  // Sync reset, active low
   input wire logic tag_valid_r,            // Tag strobe
   input wire tstamp_pkg::msg_tag_t tag_r,  // Received tag
   output logic gap_r,                      // Counter gap seen
   output logic [15:0] seen_r               // Messages taken
);
   // Gap watch: a lost message shows as a skipped count
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         gap_r <= 1'b0;
         seen_r <= 16'h0000;
      end else if (tag_valid_r) begin
         if (tag_r.has.add_count && tag_r.count !== seen_r) gap_r <= 1'b1;
         seen_r <= seen_r + 16'h0001;
      end
   end
endmodule : tag_sink

// file: tb/timestamp_packet_counter_tb_top.sv
// Testbench top for the time stamp and packet counter unit.
// Assumes the package is compiled first; one 250 MHz clock.
`timescale 1ns/1ps
module timestamp_packet_counter_tb_top;
   // ----------------------------------------
   // Stimulus and wiring
   // ----------------------------------------
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   tstamp_pkg::tag_cfg_t cfg = '0;
   logic compose = 1'b0;
   logic nvm_load = 1'b0;
   logic sat_load = 1'b0;
   tstamp_pkg::cal_time_t nvm_time = '0;
   tstamp_pkg::cal_time_t sat_time = '0;
   tstamp_pkg::msg_tag_t tag_r;
   logic tag_valid_r;
   tstamp_pkg::cal_time_t cal_r;
   logic [31:0] fine_r;
   logic [2:0] src_r;
   logic gap_r;
   logic [15:0] seen_r;
   int err_total = 0;
   int total_checks = 0;
   int cyc_n = 0;

   always #2 core_clk = ~core_clk;

   timestamp_packet_counter dut_u (.core_clk(core_clk), .rst_n(rst_n), .cfg(cfg), .compose(compose),
      .nvm_load(nvm_load), .nvm_time(nvm_time), .sat_load(sat_load), .sat_time(sat_time), .tag_r(tag_r),
      .tag_valid_r(tag_valid_r), .cal_r(cal_r), .fine_r(fine_r), .src_r(src_r));
   tag_sink sink_u (.core_clk(core_clk), .rst_n(rst_n), .tag_valid_r(tag_valid_r), .tag_r(tag_r),
      .gap_r(gap_r), .seen_r(seen_r));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic step();
      @(posedge core_clk);
      #1;
   endtask : step

   task automatic chk(input logic [147:0] got, input logic [147:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   function automatic tstamp_pkg::cal_time_t mk(input logic [31:0] ns, input logic [15:0] y,
      input logic [7:0] mo, input logic [7:0] d, input logic [23:0] hms, input logic [7:0] f);
      return {ns, y, mo, d, hms, f};
   endfunction : mk

   task automatic give_verdict();
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : give_verdict

   // Hang guard, sized for two fine ticks plus margin
   always @(posedge core_clk) begin
      cyc_n++;
      if (cyc_n == 60000) begin
         err_total++;
         give_verdict();
      end
   end

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      chk(cal_r, mk(32'h0, 16'd1999, 8'h01, 8'h01, 24'h0, 8'h00));
      chk(cal_r[95-8*tstamp_pkg::OFS_YEAR -: 16], 16'd1999);
      chk({src_r, fine_r, tag_valid_r}, {3'b001, 33'h0});
   endtask : t_reset

   // Back-to-back composes through every tag selection
   task automatic t_tags();
      tstamp_pkg::msg_tag_t exp;
      for (int i = 0; i < 9; i++) begin
         compose = (i < 8);
         cfg = i[2:0];
         if (i > 0) chk({tag_valid_r, tag_r}, {1'b1, exp});
         exp.has = cfg;
         exp.count = cfg.add_count ? i[15:0] : 16'h0000;
         exp.cal = cfg.add_cal ? cal_r : '0;
         exp.fine = cfg.add_fine ? fine_r : 32'h0;
         step();
      end
      chk(tag_valid_r, 1'b0);
   endtask : t_tags

   // Source priority: satellite beats stored, stored refused after
   task automatic t_loads();
      nvm_time = mk(32'h100, 16'd2010, 8'h05, 8'h06, 24'h070809, 8'h01);
      sat_time = mk(32'h200, 16'd2020, 8'h0a, 8'h0b, 24'h0c0d0e, 8'h07);
      nvm_load = 1'b1;
      step();
      chk({src_r, cal_r}, {3'b010, nvm_time});
      sat_load = 1'b1;
      step();
      sat_load = 1'b0;
      chk({src_r, cal_r}, {3'b100, sat_time});
      step();
      nvm_load = 1'b0;
      chk({src_r, cal_r}, {3'b100, sat_time + {32'h4, 64'h0}});
   endtask : t_loads

   // Carries across second, hour, midnight, month and year ends
   task automatic t_roll();
      tstamp_pkg::cal_time_t st[7];
      tstamp_pkg::cal_time_t ex[7];
      st[0] = mk(32'd999999996, 16'd2000, 8'd2, 8'd28, 24'h173b3b, 8'h07);
      ex[0] = mk(32'd0, 16'd2000, 8'd2, 8'd29, 24'h0, 8'h07);
      st[1] = mk(32'd999999996, 16'd1999, 8'd2, 8'd28, 24'h173b3b, 8'h04);
      ex[1] = mk(32'd0, 16'd1999, 8'd3, 8'd1, 24'h0, 8'h04);
      st[2] = mk(32'd999999996, 16'd1999, 8'd12, 8'd31, 24'h173b3b, 8'h02);
      ex[2] = mk(32'd0, 16'd2000, 8'd1, 8'd1, 24'h0, 8'h02);
      st[3] = mk(32'd999999996, 16'd2001, 8'd4, 8'd30, 24'h173b3b, 8'h01);
      ex[3] = mk(32'd0, 16'd2001, 8'd5, 8'd1, 24'h0, 8'h01);
      st[4] = mk(32'd999999996, 16'd2001, 8'd5, 8'd10, 24'h0a3b3b, 8'h00);
      ex[4] = mk(32'd0, 16'd2001, 8'd5, 8'd10, 24'h0b0000, 8'h00);
      st[5] = mk(32'd999999996, 16'd2001, 8'd5, 8'd10, 24'h0a0b1e, 8'h00);
      ex[5] = mk(32'd0, 16'd2001, 8'd5, 8'd10, 24'h0a0b1f, 8'h00);
      st[6] = mk(32'd999999996, 16'd2099, 8'd12, 8'd31, 24'h173b3b, 8'h04);
      ex[6] = mk(32'd0, 16'd2099, 8'd12, 8'd31, 24'h0, 8'h04);
      for (int i = 0; i < 7; i++) begin
         sat_time = st[i];
         sat_load = 1'b1;
         step();
         sat_load = 1'b0;
         chk(cal_r, st[i]);
         step();
         chk(cal_r, ex[i]);
      end
   endtask : t_roll

   // Fine stamp steps once per 0.1 ms
   task automatic t_fine();
      logic [31:0] f0;
      int n;
      n = 0;
      f0 = fine_r;
      while (fine_r === f0 && n < 26000) begin
         step();
         n++;
      end
      f0 = fine_r;
      n = 0;
      while (fine_r === f0 && n < 26000) begin
         step();
         n++;
      end
      chk(n, tstamp_pkg::FINE_TICK_CYC);
      chk(fine_r, f0 + 32'h1);
   endtask : t_fine

   initial begin
      repeat (10) step();
      t_reset();
      rst_n = 1'b1;
      t_tags();
      t_loads();
      t_roll();
      t_fine();
      chk({gap_r, seen_r}, {1'b0, 16'h0008});
      give_verdict();
   end
endmodule : timestamp_packet_counter_tb_top
